// *** hw/dbsp_pkg.sv ***
// shared constants for the burst-of-two sram port
package dbsp_pkg;
  localparam int          DBSP_LANE_W     = 9;
  localparam int          DBSP_LANES      = 4;
  localparam int          DBSP_ADDR_W     = 19;
  localparam int          DBSP_SYNC_DEPTH = 3;
  localparam int          DBSP_CLK_PINS   = 4;
  localparam logic [3:0]  DBSP_CLK_RST    = 4'h0;
  localparam logic        DBSP_FLAG_RST   = 1'b0;
  localparam logic        DBSP_ADDR_STEP  = 1'b1;
endpackage

// *** hw/dbsp_array.sv ***
// storage array with lane-masked two-word write and two registered reads
`timescale 1ns/1ps
module dbsp_array
  import dbsp_pkg::*;
#(
  parameter int AW     = DBSP_ADDR_W,
  parameter int LANES  = DBSP_LANES,
  parameter int LANE_W = DBSP_LANE_W
) (
  input  wire logic                      clk_i,
  input  wire logic                      wr_en_i,
  input  wire logic [AW-1:0]             wr_addr0_i,
  input  wire logic [AW-1:0]             wr_addr1_i,
  input  wire logic [LANES*LANE_W-1:0]   wr_data0_i,
  input  wire logic [LANES*LANE_W-1:0]   wr_data1_i,
  input  wire logic [LANES-1:0]          wr_lane0_n_i,
  input  wire logic [LANES-1:0]          wr_lane1_n_i,
  input  wire logic [AW-1:0]             rd_addr_a_i,
  input  wire logic [AW-1:0]             rd_addr_b_i,
  output logic      [LANES*LANE_W-1:0]   rd_data_a_o,
  output logic      [LANES*LANE_W-1:0]   rd_data_b_o
);
  genvar l;
  generate
    for (l = 0; l < LANES; l++) begin : g_lane
      logic [LANE_W-1:0] mem [2**AW];
      logic [LANE_W-1:0] rd_a;
      logic [LANE_W-1:0] rd_b;
      always_ff @(posedge clk_i) begin
        if (wr_en_i && !wr_lane0_n_i[l]) begin
          mem[wr_addr0_i] <= wr_data0_i[l*LANE_W +: LANE_W];
        end
        if (wr_en_i && !wr_lane1_n_i[l]) begin
          mem[wr_addr1_i] <= wr_data1_i[l*LANE_W +: LANE_W];
        end
        rd_a <= mem[rd_addr_a_i];
        rd_b <= mem[rd_addr_b_i];
      end
      assign rd_data_a_o[l*LANE_W +: LANE_W] = rd_a;
      assign rd_data_b_o[l*LANE_W +: LANE_W] = rd_b;
    end
  endgenerate
endmodule

// *** hw/dbsp_port.sv ***
// burst-of-two ddr sram port: sampled pins, read pipeline, write buffer
//
// Overview of operation
// - second burst address is first plus one
// - read select low at primary rise starts read
// - write select low at primary rise starts write
// - read and write machines run independently
// - commands and write machine advance on primary timebase, read pipeline on readout clocks
// - first read beat on inverted readout rise t+1.5
// - second read beat on readout rise t+2.0
// - active-low lane strobe per nine-bit lane, beat
// - write address taken on inverted primary rise
// - reads return latest buffered write data
// - readout clocks tied high: use primary clocks
// - idle read cycle never cuts a burst short
`timescale 1ns/1ps
module dbsp_port
  import dbsp_pkg::*;
#(
  parameter int AW     = DBSP_ADDR_W,
  parameter int LANES  = DBSP_LANES,
  parameter int LANE_W = DBSP_LANE_W
) (
  input  wire logic                      mclk_i,
  input  wire logic                      rst_i,
  input  wire logic                      primary_timebase_i,
  input  wire logic                      primary_timebase_inv_i,
  input  wire logic                      readout_timebase_i,
  input  wire logic                      readout_timebase_inv_i,
  input  wire logic                      read_select_n_i,
  input  wire logic                      write_select_n_i,
  input  wire logic [AW-1:0]             addr_i,
  input  wire logic [LANES*LANE_W-1:0]   wdata_i,
  input  wire logic [LANES-1:0]          byte_write_n_i,
  output logic      [LANES*LANE_W-1:0]   rdata_o,
  output logic                           rdata_oe_o
);
  localparam int DW   = LANES * LANE_W;
  localparam int IN_W = DBSP_CLK_PINS + 2 + AW + DW + LANES;

  typedef enum logic {DBSP_WR_IDLE, DBSP_WR_SECOND} dbsp_wr_state_t;

  // three-stage pin sampler
  logic [IN_W-1:0] sync_a;
  logic [IN_W-1:0] sync_b;
  logic [IN_W-1:0] sync_c;
  wire  [IN_W-1:0] pins_in = {primary_timebase_i, primary_timebase_inv_i, readout_timebase_i,
                              readout_timebase_inv_i, read_select_n_i, write_select_n_i,
                              addr_i, wdata_i, byte_write_n_i};

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end else begin
      sync_a <= pins_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  wire [3:0]       clk_b  = sync_b[IN_W-1 -: DBSP_CLK_PINS];
  wire [3:0]       clk_c  = sync_c[IN_W-1 -: DBSP_CLK_PINS];
  wire             rsel_n = sync_c[IN_W-DBSP_CLK_PINS-1];
  wire             wsel_n = sync_c[IN_W-DBSP_CLK_PINS-2];
  wire [AW-1:0]    addr_s = sync_c[DW+LANES +: AW];
  wire [DW-1:0]    wdat_s = sync_c[LANES +: DW];
  wire [LANES-1:0] bw_n_s = sync_c[LANES-1:0];

  // clock levels accepted once stages two and three agree
  logic [3:0] clk_lvl;
  wire  [3:0] clk_agree    = ~(clk_b ^ clk_c);
  wire  [3:0] next_clk_lvl = (clk_agree & clk_c) | (~clk_agree & clk_lvl);
  wire  [3:0] clk_rise     = clk_agree & clk_c & ~clk_lvl;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_lvl <= DBSP_CLK_RST;
    end else begin
      clk_lvl <= next_clk_lvl;
    end
  end

  wire k_rise   = clk_rise[3];
  wire kn_rise  = clk_rise[2];
  wire k_output = clk_lvl[1] & clk_lvl[0];
  wire oc_rise  = k_output ? clk_rise[3] : clk_rise[1];
  wire ocn_rise = k_output ? clk_rise[2] : clk_rise[0];

  // commands sampled only on primary rising edges
  wire rd_cmd = k_rise & ~rsel_n;
  wire wr_cmd = k_rise & ~wsel_n;

  // read pipeline: queued, first-beat stage, second-beat stage
  logic          q0_v;
  logic [AW-1:0] q0_a;
  logic          st1_v;
  logic [AW-1:0] st1_a;
  logic          st2_v;
  logic [AW-1:0] st2_a;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q0_v <= DBSP_FLAG_RST;
      q0_a <= '0;
    end else if (rd_cmd) begin
      q0_v <= 1'b1;
      q0_a <= addr_s;
    end else if (ocn_rise) begin
      q0_v <= DBSP_FLAG_RST;
    end
  end

  // idle cycles only stop new entries, staged bursts run out
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st1_v <= DBSP_FLAG_RST;
      st1_a <= '0;
      st2_v <= DBSP_FLAG_RST;
      st2_a <= '0;
    end else if (ocn_rise) begin
      st1_v <= q0_v;
      st1_a <= q0_a;
      st2_v <= st1_v;
      st2_a <= st1_a;
    end else if (oc_rise) begin
      st2_v <= DBSP_FLAG_RST;
    end
  end

  // write machine, independent of the read pipeline
  dbsp_wr_state_t wr_state;
  logic [DW-1:0]    stg_d0;
  logic [LANES-1:0] stg_bw0;
  logic             buf_v;
  logic [AW-1:0]    buf_a;
  logic [DW-1:0]    buf_d0;
  logic [DW-1:0]    buf_d1;
  logic [LANES-1:0] buf_bw0;
  logic [LANES-1:0] buf_bw1;
  logic             commit;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_state <= DBSP_WR_IDLE;
      stg_d0   <= '0;
      stg_bw0  <= '1;
      buf_v    <= DBSP_FLAG_RST;
      buf_a    <= '0;
      buf_d0   <= '0;
      buf_d1   <= '0;
      buf_bw0  <= '1;
      buf_bw1  <= '1;
      commit   <= DBSP_FLAG_RST;
    end else begin
      commit <= DBSP_FLAG_RST;
      case (wr_state)
        DBSP_WR_IDLE: begin
          if (wr_cmd) begin
            stg_d0   <= wdat_s;
            stg_bw0  <= bw_n_s;
            wr_state <= DBSP_WR_SECOND;
          end
        end
        DBSP_WR_SECOND: begin
          if (kn_rise) begin
            buf_a    <= addr_s;
            buf_d0   <= stg_d0;
            buf_bw0  <= stg_bw0;
            buf_d1   <= wdat_s;
            buf_bw1  <= bw_n_s;
            buf_v    <= 1'b1;
            commit   <= 1'b1;
            wr_state <= DBSP_WR_IDLE;
          end
        end
        default: begin
          wr_state <= DBSP_WR_IDLE;
        end
      endcase
    end
  end

  wire [AW-1:0] buf_a1  = buf_a + AW'(DBSP_ADDR_STEP);
  wire [AW-1:0] st2_a1  = st2_a + AW'(DBSP_ADDR_STEP);
  wire [DW-1:0] mem_a;
  wire [DW-1:0] mem_b;

  dbsp_array #(
    .AW     (AW),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_array (
    .clk_i        (mclk_i),
    .wr_en_i      (commit),
    .wr_addr0_i   (buf_a),
    .wr_addr1_i   (buf_a1),
    .wr_data0_i   (buf_d0),
    .wr_data1_i   (buf_d1),
    .wr_lane0_n_i (buf_bw0),
    .wr_lane1_n_i (buf_bw1),
    .rd_addr_a_i  (st1_a),
    .rd_addr_b_i  (st2_a1),
    .rd_data_a_o  (mem_a),
    .rd_data_b_o  (mem_b)
  );

  // buffered write data overrides the array per enabled lane
  wire hit0_a = buf_v & (st1_a == buf_a);
  wire hit1_a = buf_v & (st1_a == buf_a1);
  wire hit0_b = buf_v & (st2_a1 == buf_a);
  wire hit1_b = buf_v & (st2_a1 == buf_a1);
  wire [DW-1:0] merged_a;
  wire [DW-1:0] merged_b;

  genvar l;
  generate
    for (l = 0; l < LANES; l++) begin : g_merge
      wire sel0_a = hit0_a & ~buf_bw0[l];
      wire sel1_a = hit1_a & ~buf_bw1[l];
      wire sel0_b = hit0_b & ~buf_bw0[l];
      wire sel1_b = hit1_b & ~buf_bw1[l];
      assign merged_a[l*LANE_W +: LANE_W] = sel1_a ? buf_d1[l*LANE_W +: LANE_W] :
                                            sel0_a ? buf_d0[l*LANE_W +: LANE_W] :
                                                     mem_a[l*LANE_W +: LANE_W];
      assign merged_b[l*LANE_W +: LANE_W] = sel1_b ? buf_d1[l*LANE_W +: LANE_W] :
                                            sel0_b ? buf_d0[l*LANE_W +: LANE_W] :
                                                     mem_b[l*LANE_W +: LANE_W];
    end
  endgenerate

  // outputs change only on output clock edges, so they hold when clocks stop
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o    <= '0;
      rdata_oe_o <= DBSP_FLAG_RST;
    end else if (ocn_rise) begin
      rdata_oe_o <= st1_v;
      if (st1_v) begin
        rdata_o <= merged_a;
      end
    end else if (oc_rise) begin
      rdata_oe_o <= st2_v;
      if (st2_v) begin
        rdata_o <= merged_b;
      end
    end
  end
endmodule

// *** sim/dbsp_port_props.sv ***
// checker: read beat timing and clock-stop hold at the sram port pins
`timescale 1ns/1ps
module dbsp_port_props
  import dbsp_pkg::*;
#(
  parameter int AW     = DBSP_ADDR_W,
  parameter int LANES  = DBSP_LANES,
  parameter int LANE_W = DBSP_LANE_W
) (
  input wire logic                    mclk_i,
  input wire logic                    rst_i,
  input wire logic                    primary_timebase_i,
  input wire logic                    primary_timebase_inv_i,
  input wire logic                    readout_timebase_i,
  input wire logic                    readout_timebase_inv_i,
  input wire logic                    read_select_n_i,
  input wire logic                    write_select_n_i,
  input wire logic [AW-1:0]           addr_i,
  input wire logic [LANES*LANE_W-1:0] wdata_i,
  input wire logic [LANES-1:0]        byte_write_n_i,
  input wire logic [LANES*LANE_W-1:0] rdata_o,
  input wire logic                    rdata_oe_o
);
  logic [5:0] rd_age;
  logic [2:0] quiet;
  logic [2:0] rd_hist;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // cycles since last read command (frozen while clocks stand), read history per K rise,
  // and cycles since any clock pin moved
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_age  <= 6'h3F;
      quiet   <= 3'h0;
      rd_hist <= 3'h0;
    end else begin
      if ($rose(primary_timebase_i) && !read_select_n_i) rd_age <= 6'h00;
      else if (rd_age != 6'h3F && quiet != 3'h7) rd_age <= rd_age + 6'h01;
      if ($rose(primary_timebase_i)) rd_hist <= {rd_hist[1:0], !read_select_n_i};
      if (!$stable({primary_timebase_i, primary_timebase_inv_i, readout_timebase_i, readout_timebase_inv_i}))
        quiet <= 3'h0;
      else if (quiet != 3'h7) quiet <= quiet + 3'h1;
    end
  end
  hold_stop_a: assert property (quiet == 3'h7 |-> $stable(rdata_o) && $stable(rdata_oe_o))
    else $error("output moved with clocks stopped");
  read_start_a: assert property (rd_age == 6'h0C |-> ##[0:8] rdata_oe_o)
    else $error("read beat missing");
  two_beats_a: assert property ($rose(rdata_oe_o) |-> rdata_oe_o[*8])
    else $error("burst cut short");
  rise_cause_a: assert property ($rose(rdata_oe_o) |-> rd_age <= 6'h14)
    else $error("output without read");
  no_stray_a: assert property (rdata_oe_o |-> rd_age <= 6'h1A)
    else $error("output held too long");
  fall_late_a: assert property ($fell(rdata_oe_o) |-> rd_hist[2:1] == 2'b10)
    else $error("output dropped early");
  fall_keep_a: assert property ($fell(rdata_oe_o) |-> $stable(rdata_o))
    else $error("data moved at drop");
  change_oe_a: assert property ($changed(rdata_o) |-> rdata_oe_o)
    else $error("data moved while idle");
  cover property ($rose(rdata_oe_o));
  cover property ($fell(rdata_oe_o));
  cover property (quiet == 3'h7);
  cover property (quiet == 3'h7 && rdata_oe_o);
endmodule
bind dbsp_port dbsp_port_props #(.AW(AW), .LANES(LANES), .LANE_W(LANE_W)) props_u (.*);

// *** sim/dbsp_ctrl_model.sv ***
// controller model: timebases, selects, address and write beats
`timescale 1ns/1ps
module dbsp_ctrl_model (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic         stop_i,
  input  wire logic         single_i,
  input  wire logic [119:0] cmd_i,
  output logic      [2:0]   ph_o,
  output logic              k_o,
  output logic              kn_o,
  output logic              c_o,
  output logic              cn_o,
  output logic              rsn_o,
  output logic              wsn_o,
  output logic      [18:0]  a_o,
  output logic      [35:0]  d_o,
  output logic      [3:0]   bwn_o
);
  logic rs;
  logic ws;
  assign k_o   = !ph_o[2];
  assign kn_o  = ph_o[2];
  assign c_o   = single_i | k_o;
  assign cn_o  = single_i | kn_o;
  // selects forced low while stopped; no edge may start anything
  assign rsn_o = rs & !stop_i;
  assign wsn_o = ws & !stop_i;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ph_o  <= 3'h0;
      rs    <= 1'b1;
      ws    <= 1'b1;
      a_o   <= 19'h0;
      d_o   <= 36'h0;
      bwn_o <= 4'hF;
    end else if (!stop_i) begin
      ph_o <= ph_o + 3'h1;
      if (ph_o == 3'h5) begin
        {rs, ws, a_o, d_o, bwn_o} <= {cmd_i[119:99], cmd_i[79:44], cmd_i[7:4]};
      end
      if (ph_o == 3'h1) begin
        a_o   <= ws ? ~a_o : cmd_i[98:80];
        d_o   <= ws ? ~d_o : cmd_i[43:8];
        bwn_o <= ws ? ~bwn_o : cmd_i[3:0];
      end
    end
  end
endmodule

// *** sim/testbench.sv ***
// testbench: random and corner bursts against a reference array
`timescale 1ns/1ps
module testbench;
  import dbsp_pkg::*;
  logic         mclk = 1'b0;
  logic         rst = 1'b1;
  logic         stop = 1'b0;
  logic         single = 1'b0;
  logic [119:0] cmd = {2'h3, 118'h0};
  logic [35:0]  mem [0:31];
  logic [35:0]  e0 [0:2];
  logic [35:0]  e1 [0:2];
  logic [2:0]   v = 3'h0;
  logic [2:0]   ph;
  logic [18:0]  a, ra, wa;
  logic [35:0]  d, rd, r0, r1, hd;
  logic [3:0]   bwn;
  logic [1:0]   op;
  logic [4:0]   pa = 5'h0;
  logic         k, kn, c, cn, rsn, wsn, oe, ho;
  int           error_cnt = 0;
  int           num_checks = 0;
  int           cyc = 0;
  dbsp_ctrl_model ctrl_u (.mclk_i(mclk), .rst_i(rst), .stop_i(stop), .single_i(single), .cmd_i(cmd), .ph_o(ph),
    .k_o(k), .kn_o(kn), .c_o(c), .cn_o(cn), .rsn_o(rsn), .wsn_o(wsn), .a_o(a), .d_o(d), .bwn_o(bwn));
  dbsp_port dut_u (.mclk_i(mclk), .rst_i(rst), .primary_timebase_i(k), .primary_timebase_inv_i(kn),
    .readout_timebase_i(c), .readout_timebase_inv_i(cn), .read_select_n_i(rsn), .write_select_n_i(wsn),
    .addr_i(a), .wdata_i(d), .byte_write_n_i(bwn), .rdata_o(rd), .rdata_oe_o(oe));
  task automatic chk(string n, logic [35:0] e, logic [35:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one K cycle: check beats of the read three cycles back, then issue
  task automatic step(logic rn, logic wn, logic [18:0] ra, logic [18:0] wa, logic [35:0] d0, logic [35:0] d1,
                      logic [3:0] b0, logic [3:0] b1);
    do begin
      @(posedge mclk);
      #1;
      if (ph == 3'h1 && v[2]) chk("beat0", e0[2], rd);
      if (ph == 3'h1) chk("oe0", {35'h0, v[2]}, {35'h0, oe});
    end while (ph != 3'h5);
    if (v[2]) chk("beat1", e1[2], rd);
    chk("oe1", {35'h0, v[2]}, {35'h0, oe});
    e0[2] = e0[1];
    e0[1] = e0[0];
    e1[2] = e1[1];
    e1[1] = e1[0];
    v = {v[1:0], !rn};
    e0[0] = mem[ra[4:0]];
    e1[0] = mem[ra[4:0] + 5'h1];
    // this write is buffered before the previous read's second beat leaves
    for (int l = 0; l < 4; l++) begin
      if (!wn && !b0[l]) mem[wa[4:0]][9*l+:9] = d0[9*l+:9];
      if (!wn && !b1[l]) mem[wa[4:0] + 5'h1][9*l+:9] = d1[9*l+:9];
      if (!wn && !b0[l] && wa[4:0] == pa) e1[1][9*l+:9] = d0[9*l+:9];
      if (!wn && !b1[l] && wa[4:0] + 5'h1 == pa) e1[1][9*l+:9] = d1[9*l+:9];
    end
    pa = ra[4:0] + 5'h1;
    cmd = {rn, wn, ra, wa, d0, d1, b0, b1};
  endtask
  initial begin
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h42B9));
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    for (int i = 0; i < 32; i += 2) begin
      r0 = 36'({$urandom, $urandom});
      step(1'b1, 1'b0, 19'h0, 19'(i), r0, ~r0, 4'h0, 4'h0);
    end
    r1 = 36'({$urandom, $urandom});
    step(1'b1, 1'b0, 19'h0, 19'h4, r0, r1, 4'hF, 4'h6);
    step(1'b0, 1'b1, 19'h4, 19'h0, r0, r1, 4'hF, 4'hF);
    for (int m = 0; m < 2; m++) begin
      single = m[0];
      for (int i = 0; i < 80; i++) begin
        op = 2'($urandom);
        ra = 19'($urandom % 15);
        wa = op[0] ? ra + 19'h10 : 19'($urandom % 31);
        r0 = 36'({$urandom, $urandom});
        r1 = 36'({$urandom, $urandom});
        step(!op[0], !op[1], ra, wa, r0, r1, 4'($urandom), 4'($urandom));
      end
      repeat (4) step(1'b1, 1'b1, 19'h0, 19'h0, r0, r1, 4'hF, 4'hF);
    end
    // stop with bursts in flight; the edge already seen still completes
    for (int i = 0; i < 3; i++) step(1'b0, 1'b1, 19'(4 * i), 19'h0, r0, r1, 4'hF, 4'hF);
    stop = 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    hd = rd;
    ho = oe;
    chk("stop beat", e0[2], hd);
    chk("stop held oe", 36'h1, {35'h0, ho});
    repeat (32) @(posedge mclk);
    chk("stop data", hd, rd);
    chk("stop oe", {35'h0, ho}, {35'h0, oe});
    #1 stop = 1'b0;
    repeat (4) step(1'b1, 1'b1, 19'h0, 19'h0, r0, r1, 4'hF, 4'hF);
    wrap_up();
  end
endmodule
